// ---- ldcb_bank.sv ----
`timescale 1ns/10ps
module ldcb_bank
  import ldcb_pkg::*;
#(
  parameter int UNITS = NUM_UNITS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration state and unit number
  input wire logic cfg_mode,
  input wire logic [LDN_W-1:0] ldn,
  // index and data port access
  input wire ldcb_io_s host_io,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // chip-level power control link
  input wire logic pwr_wr,
  input wire logic [UNITS-1:0] pwr_bits,
  // host address decode
  input wire logic [11:0] host_addr,
  // per-unit results and interrupt edge polarity
  output ldcb_cfg_s unit_cfg [UNITS],
  output logic [UNITS-1:0] unit_on,
  output logic [UNITS-1:0] addr_hit,
  output logic irq_edge_high
);

  logic [7:0] index;
  logic [7:0] next_index;
  logic [7:0] next_rd_data;
  logic next_rd_valid;
  logic [UNITS-1:0] next_unit_on;
  logic [UNITS-1:0] next_addr_hit;
  logic [UNITS-1:0] unit_wr;
  logic [UNITS-1:0] base_ok;
  logic [7:0] unit_rd [UNITS];
  logic acc_wr;
  logic acc_rd;
  logic data_wr;
  logic data_rd;
  logic bank_idx;

  // host access qualified by configuration state
  assign acc_wr = host_io.wr && cfg_mode;
  assign acc_rd = host_io.rd && cfg_mode;
  assign data_wr = acc_wr && (host_io.port == PORT_DATA);
  assign data_rd = acc_rd && (host_io.port == PORT_DATA);
  assign bank_idx = (index >= IDX_FIRST);

  function automatic logic in_window(input logic [15:0] b, input logic pp);
    logic ok;
    ok = 1'b0;
    if (pp) begin
      ok = (b >= BASE_MIN) && (b <= BASE_MAX_PP) && (b[1:0] == 2'b00);
    end else begin
      ok = (b >= BASE_MIN) && (b <= BASE_MAX) && (b[2:0] == 3'b000);
    end
    return ok;
  endfunction

  genvar g;
  generate
    for (g = 0; g < UNITS; g++) begin : g_unit
      assign unit_wr[g] = data_wr && bank_idx && (ldn == LDN_W'(g));
      ldcb_unit #(
        .PRESENT(M_PRESENT[g]),
        .HAS_B1(M_BASE1[g]),
        .HAS_B2(M_BASE2[g]),
        .HAS_IRQ2(M_IRQ2[g]),
        .HAS_DMA(M_DMA[g])
      ) u_unit (
        .clk(clk),
        .rst(rst),
        .wr_en(unit_wr[g]),
        .idx(index),
        .wdata(host_io.data),
        .pwr_wr(pwr_wr),
        .pwr_val(pwr_bits[g]),
        .cfg(unit_cfg[g]),
        .rdata(unit_rd[g])
      );
      // unit with a base outside its window decodes nothing
      assign base_ok[g] = M_BASE1[g] ? in_window(unit_cfg[g].base1, (g == LDN_PP))
                                     : (g == LDN_KBD);
    end
  endgenerate

  // index port and data port read path
  always_comb begin
    next_index = index;
    next_rd_data = rd_data;
    next_rd_valid = 1'b0;
    if (acc_wr && (host_io.port == PORT_INDEX)) begin
      next_index = host_io.data;
    end
    if (acc_rd) begin
      next_rd_valid = 1'b1;
      if (host_io.port == PORT_INDEX) begin
        next_rd_data = index;
      end else if (bank_idx && (ldn < LDN_W'(UNITS))) begin
        next_rd_data = unit_rd[ldn[3:0]];
      end else begin
        next_rd_data = 8'h00;
      end
    end
  end

  // unit power and address decode
  always_comb begin
    for (int i = 0; i < UNITS; i++) begin
      next_unit_on[i] = unit_cfg[i].act || pwr_bits[i];
      next_addr_hit[i] = 1'b0;
      if (next_unit_on[i] && base_ok[i]) begin
        if (i == LDN_KBD) begin
          next_addr_hit[i] = (host_addr == KBD_DATA) || (host_addr == KBD_CMD);
        end else if ((i == LDN_PP) && (unit_cfg[i].base1[2] == 1'b1)) begin
          next_addr_hit[i] = (host_addr[11:2] == unit_cfg[i].base1[11:2]);
        end else begin
          next_addr_hit[i] = (host_addr[11:3] == unit_cfg[i].base1[11:3]);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      index <= 8'h00;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      unit_on <= '0;
      addr_hit <= '0;
      irq_edge_high <= 1'b1;
    end else begin
      index <= next_index;
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      unit_on <= next_unit_on;
      addr_hit <= next_addr_hit;
      irq_edge_high <= 1'b1;
    end
  end

  property p_no_access_outside_cfg;
    @(posedge clk) disable iff (rst)
    (host_io.rd && !cfg_mode) |=> !rd_valid;
  endproperty
  a_no_access_outside_cfg: assert property (p_no_access_outside_cfg)
    else $error("read answered outside configuration state");

  property p_index_then_data;
    @(posedge clk) disable iff (rst)
    (data_wr && (index == IDX_IRQ1) && (ldn == 8'h00) && !pwr_wr)
      |=> (unit_cfg[0].irq1 == $past(host_io.data[3:0]));
  endproperty
  a_index_then_data: assert property (p_index_then_data)
    else $error("data write did not reach the indexed register");

  property p_reserved_low;
    @(posedge clk) disable iff (rst)
    (data_rd && (index >= IDX_RSV_LO) && (index <= IDX_RSV_HI))
      |=> (rd_valid && (rd_data == 8'h00));
  endproperty
  a_reserved_low: assert property (p_reserved_low)
    else $error("reserved index read nonzero");

  property p_unimplemented;
    @(posedge clk) disable iff (rst)
    (data_rd && ((index == 8'h71) || (index == 8'h73)
      || ((index >= IDX_UNI_LO) && (index <= IDX_UNI_HI))))
      |=> (rd_data == 8'h00);
  endproperty
  a_unimplemented: assert property (p_unimplemented)
    else $error("unimplemented index read nonzero");

  property p_act_reserved_bits;
    @(posedge clk) disable iff (rst)
    (data_rd && (index == IDX_ACT)) |=> (rd_data[7:1] == 7'h00);
  endproperty
  a_act_reserved_bits: assert property (p_act_reserved_bits)
    else $error("activate reserved bits read nonzero");

  property p_irq2_only_kbd;
    @(posedge clk) disable iff (rst)
    (data_rd && (index == IDX_IRQ2) && (ldn != LDN_W'(LDN_KBD))) |=> (rd_data == 8'h00);
  endproperty
  a_irq2_only_kbd: assert property (p_irq2_only_kbd)
    else $error("second interrupt select nonzero on non-keyboard unit");

  property p_unit_on;
    @(posedge clk) disable iff (rst)
    ##1 (unit_on[0] == ($past(unit_cfg[0].act) || $past(pwr_bits[0])));
  endproperty
  a_unit_on: assert property (p_unit_on)
    else $error("unit power state not activate or power bit");

  property p_power_link;
    @(posedge clk) disable iff (rst)
    (pwr_wr && !unit_wr[0]) |=> (unit_cfg[0].act == $past(pwr_bits[0]))
      ##1 (unit_on[0] == ($past(pwr_bits[0], 2) || $past(pwr_bits[0])));
  endproperty
  a_power_link: assert property (p_power_link)
    else $error("activate bit did not follow power bit");

  property p_hit_needs_window;
    @(posedge clk) disable iff (rst)
    addr_hit[LDN_PP] |-> in_window($past(unit_cfg[LDN_PP].base1), 1'b1);
  endproperty
  a_hit_needs_window: assert property (p_hit_needs_window)
    else $error("decode hit with base outside window");

  property p_edge_high;
    @(posedge clk) disable iff (rst)
    $rose(host_io.rd) |-> irq_edge_high ##1 irq_edge_high;
  endproperty
  a_edge_high: assert property (p_edge_high)
    else $error("interrupt signalling not edge high");

  property p_read_answered;
    @(posedge clk) disable iff (rst)
    acc_rd |=> rd_valid;
  endproperty
  a_read_answered: assert property (p_read_answered)
    else $error("accepted read gave no answer");

  property p_answer_needs_read;
    @(posedge clk) disable iff (rst)
    rd_valid |-> $past(acc_rd);
  endproperty
  a_answer_needs_read: assert property (p_answer_needs_read)
    else $error("read answer without accepted read");

  property p_index_write;
    @(posedge clk) disable iff (rst)
    (acc_wr && (host_io.port == PORT_INDEX)) |=> (index == $past(host_io.data));
  endproperty
  a_index_write: assert property (p_index_write)
    else $error("index port write not taken");

  property p_index_read;
    @(posedge clk) disable iff (rst)
    (acc_rd && (host_io.port == PORT_INDEX)) |=> (rd_data == $past(index));
  endproperty
  a_index_read: assert property (p_index_read)
    else $error("index port read wrong");

  property p_no_write_outside_cfg;
    @(posedge clk) disable iff (rst)
    (host_io.wr && !cfg_mode)
      |=> ((index == $past(index)) && (unit_cfg[0].irq1 == $past(unit_cfg[0].irq1)));
  endproperty
  a_no_write_outside_cfg: assert property (p_no_write_outside_cfg)
    else $error("write taken outside configuration state");

  property p_act_write;
    @(posedge clk) disable iff (rst)
    (unit_wr[0] && (index == IDX_ACT))
      |=> (unit_cfg[0].act == $past(host_io.data[ACT_BIT]));
  endproperty
  a_act_write: assert property (p_act_write)
    else $error("activate write not taken");

  property p_base_high;
    @(posedge clk) disable iff (rst)
    (unit_wr[LDN_PP] && (index == IDX_B1H))
      |=> (unit_cfg[LDN_PP].base1[15:8] == $past(host_io.data));
  endproperty
  a_base_high: assert property (p_base_high)
    else $error("base high byte not taken");

  property p_base_low;
    @(posedge clk) disable iff (rst)
    (unit_wr[LDN_PP] && (index == IDX_B1L))
      |=> (unit_cfg[LDN_PP].base1[7:0] == $past(host_io.data));
  endproperty
  a_base_low: assert property (p_base_low)
    else $error("base low byte not taken");

  property p_second_base_unused;
    @(posedge clk) disable iff (rst)
    (data_rd && ((index == IDX_B2H) || (index == IDX_B2L)) && (ldn == LDN_W'(LDN_KBD)))
      |=> (rd_data == 8'h00);
  endproperty
  a_second_base_unused: assert property (p_second_base_unused)
    else $error("unused base register read nonzero");

  property p_dma_unused;
    @(posedge clk) disable iff (rst)
    (data_rd && (index == IDX_DMA) && (ldn == LDN_W'(LDN_KBD))) |=> (rd_data == 8'h00);
  endproperty
  a_dma_unused: assert property (p_dma_unused)
    else $error("dma select nonzero on unit without dma");

  property p_irq_upper_zero;
    @(posedge clk) disable iff (rst)
    (data_rd && ((index == IDX_IRQ1) || (index == IDX_IRQ2))) |=> (rd_data[7:4] == 4'h0);
  endproperty
  a_irq_upper_zero: assert property (p_irq_upper_zero)
    else $error("interrupt select upper bits nonzero");

  property p_low_index_zero;
    @(posedge clk) disable iff (rst)
    (data_rd && !bank_idx) |=> (rd_data == 8'h00);
  endproperty
  a_low_index_zero: assert property (p_low_index_zero)
    else $error("index below bank read nonzero");

  property p_no_such_unit;
    @(posedge clk) disable iff (rst)
    (data_rd && (ldn >= LDN_W'(UNITS))) |=> (rd_data == 8'h00);
  endproperty
  a_no_such_unit: assert property (p_no_such_unit)
    else $error("missing unit read nonzero");

  property p_reset_values;
    @(posedge clk) disable iff (rst)
    $fell(rst) |-> ((unit_cfg[0].irq1 == RST_IRQ) && (unit_cfg[LDN_KBD].irq2 == RST_IRQ)
      && (unit_cfg[0].dma == RST_DMA));
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("select registers not at reset value");

  property p_kbd_fixed_decode;
    @(posedge clk) disable iff (rst)
    addr_hit[LDN_KBD] |-> (($past(host_addr) == KBD_DATA) || ($past(host_addr) == KBD_CMD));
  endproperty
  a_kbd_fixed_decode: assert property (p_kbd_fixed_decode)
    else $error("keyboard decode hit off its fixed ports");

  property p_pp_word_decode;
    @(posedge clk) disable iff (rst)
    (addr_hit[LDN_PP] && $past(unit_cfg[LDN_PP].base1[2]))
      |-> ($past(host_addr[11:2]) == $past(unit_cfg[LDN_PP].base1[11:2]));
  endproperty
  a_pp_word_decode: assert property (p_pp_word_decode)
    else $error("four byte decode hit off its base");

endmodule // ldcb_bank

// ---- ldcb_host_model.sv ----
`timescale 1ns/10ps
module ldcb_host_model
  import ldcb_pkg::*;
(
  // clock
  input wire logic clk,
  // host port
  output ldcb_io_s host_io,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  initial begin
    host_io = '0;
  end
  // one access, strobe held for exactly one edge
  task automatic acc(input logic wr, input logic port, input logic [7:0] d,
                     output logic [7:0] q, output logic ok);
    int i;
    q = 8'h00;
    ok = wr;
    @(negedge clk);
    host_io <= '{wr: wr, rd: ~wr, port: port, data: d};
    @(negedge clk);
    // released bus shows the inverse of the last value
    host_io <= '{wr: 1'b0, rd: 1'b0, port: ~port, data: ~d};
    for (i = 0; i < 4 && !ok; i++) begin
      if (rd_valid === 1'b1) begin
        q = rd_data;
        ok = 1'b1;
      end else begin
        @(negedge clk);
      end
    end
  endtask
endmodule // ldcb_host_model

// ---- ldcb_pkg.sv ----
package ldcb_pkg;

  // bank geometry
  localparam int NUM_UNITS = 10;
  localparam int LDN_W = 8;

  // register indices
  localparam logic [7:0] IDX_FIRST = 8'h30;
  localparam logic [7:0] IDX_ACT = 8'h30;
  localparam logic [7:0] IDX_B1H = 8'h60;
  localparam logic [7:0] IDX_B1L = 8'h61;
  localparam logic [7:0] IDX_B2H = 8'h62;
  localparam logic [7:0] IDX_B2L = 8'h63;
  localparam logic [7:0] IDX_IRQ1 = 8'h70;
  localparam logic [7:0] IDX_IRQ2 = 8'h72;
  localparam logic [7:0] IDX_DMA = 8'h74;
  localparam logic [7:0] IDX_RSV_LO = 8'h31;
  localparam logic [7:0] IDX_RSV_HI = 8'h5F;
  localparam logic [7:0] IDX_UNI_LO = 8'h75;
  localparam logic [7:0] IDX_UNI_HI = 8'hDF;

  // field positions and reset values
  localparam int ACT_BIT = 0;
  localparam logic [15:0] RST_BASE = 16'h0000;
  localparam logic [3:0] RST_IRQ = 4'h0;
  localparam logic [7:0] RST_DMA = 8'h04;

  // permitted base window and fixed keyboard ports, host address bits 11..0
  localparam logic [15:0] BASE_MIN = 16'h0100;
  localparam logic [15:0] BASE_MAX = 16'h0FF8;
  localparam logic [15:0] BASE_MAX_PP = 16'h0FFC;
  localparam logic [11:0] KBD_DATA = 12'h060;
  localparam logic [11:0] KBD_CMD = 12'h064;

  // logical unit numbers
  localparam int LDN_PP = 3;
  localparam int LDN_KBD = 7;

  // per-unit feature masks, bit n is unit n
  localparam logic [15:0] M_PRESENT = 16'h01B9;
  localparam logic [15:0] M_BASE1 = 16'h0039;
  localparam logic [15:0] M_BASE2 = 16'h0020;
  localparam logic [15:0] M_IRQ2 = 16'h0080;
  localparam logic [15:0] M_DMA = 16'h0029;

  // host port select
  localparam logic PORT_INDEX = 1'b0;
  localparam logic PORT_DATA = 1'b1;

  typedef struct packed {
    logic act;
    logic [15:0] base1;
    logic [15:0] base2;
    logic [3:0] irq1;
    logic [3:0] irq2;
    logic [7:0] dma;
  } ldcb_cfg_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic port;
    logic [7:0] data;
  } ldcb_io_s;

endpackage

// ---- ldcb_unit.sv ----
`timescale 1ns/10ps
module ldcb_unit
  import ldcb_pkg::*;
#(
  parameter bit PRESENT = 1'b1,
  parameter bit HAS_B1 = 1'b1,
  parameter bit HAS_B2 = 1'b0,
  parameter bit HAS_IRQ2 = 1'b0,
  parameter bit HAS_DMA = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register access
  input wire logic wr_en,
  input wire logic [7:0] idx,
  input wire logic [7:0] wdata,
  // power control link
  input wire logic pwr_wr,
  input wire logic pwr_val,
  // state
  output ldcb_cfg_s cfg,
  output logic [7:0] rdata
);

  localparam ldcb_cfg_s CFG_RST = '{
    act: 1'b0, base1: RST_BASE, base2: RST_BASE, irq1: RST_IRQ, irq2: RST_IRQ,
    dma: (HAS_DMA ? RST_DMA : 8'h00)};

  ldcb_cfg_s next_cfg;

  always_comb begin
    next_cfg = cfg;
    if (pwr_wr) begin
      next_cfg.act = pwr_val;
    end
    if (wr_en) begin
      case (idx)
        IDX_ACT: next_cfg.act = wdata[ACT_BIT];
        IDX_B1H: next_cfg.base1[15:8] = wdata;
        IDX_B1L: next_cfg.base1[7:0] = wdata;
        IDX_B2H: next_cfg.base2[15:8] = wdata;
        IDX_B2L: next_cfg.base2[7:0] = wdata;
        IDX_IRQ1: next_cfg.irq1 = wdata[3:0];
        IDX_IRQ2: next_cfg.irq2 = wdata[3:0];
        IDX_DMA: next_cfg.dma = wdata;
        default: next_cfg = next_cfg;
      endcase
    end
    // absent features never hold a value
    if (!PRESENT) begin
      next_cfg.act = 1'b0;
      next_cfg.irq1 = RST_IRQ;
    end
    if (!HAS_B1) begin
      next_cfg.base1 = RST_BASE;
    end
    if (!HAS_B2) begin
      next_cfg.base2 = RST_BASE;
    end
    if (!HAS_IRQ2) begin
      next_cfg.irq2 = RST_IRQ;
    end
    if (!HAS_DMA) begin
      next_cfg.dma = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg <= CFG_RST;
    end else begin
      cfg <= next_cfg;
    end
  end

  always_comb begin
    case (idx)
      IDX_ACT: rdata = {7'h00, cfg.act};
      IDX_B1H: rdata = cfg.base1[15:8];
      IDX_B1L: rdata = cfg.base1[7:0];
      IDX_B2H: rdata = cfg.base2[15:8];
      IDX_B2L: rdata = cfg.base2[7:0];
      IDX_IRQ1: rdata = {4'h0, cfg.irq1};
      IDX_IRQ2: rdata = {4'h0, cfg.irq2};
      IDX_DMA: rdata = cfg.dma;
      default: rdata = 8'h00;
    endcase
  end

endmodule // ldcb_unit

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench
  import ldcb_pkg::*;
();
  logic clk, rst, cfg_mode, pwr_wr, rd_valid, irq_edge_high, ok;
  logic [7:0] ldn, rd_data, v;
  logic [9:0] pwr_bits, unit_on, addr_hit;
  logic [11:0] host_addr;
  ldcb_io_s host_io;
  ldcb_cfg_s unit_cfg [NUM_UNITS];
  int errors, checks;
  logic [7:0] ridx [8] = '{8'h30, 8'h60, 8'h61, 8'h62, 8'h63, 8'h70, 8'h72, 8'h74};
  logic [7:0] rmsk [8] = '{8'h01, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'hFF};
  logic [15:0] rft [8] = '{M_PRESENT, M_BASE1, M_BASE1, M_BASE2, M_BASE2, M_PRESENT,
                           M_IRQ2, M_DMA};
  logic [7:0] rsv [15] = '{8'h31, 8'h37, 8'h38, 8'h3F, 8'h40, 8'h5F, 8'h64, 8'h6F,
                           8'h71, 8'h73, 8'h75, 8'h76, 8'hA8, 8'hA9, 8'hDF};

  ldcb_bank #(.UNITS(NUM_UNITS)) ldcb_bank_inst (.clk(clk), .rst(rst), .cfg_mode(cfg_mode),
    .ldn(ldn), .host_io(host_io), .rd_data(rd_data), .rd_valid(rd_valid), .pwr_wr(pwr_wr),
    .pwr_bits(pwr_bits), .host_addr(host_addr), .unit_cfg(unit_cfg), .unit_on(unit_on),
    .addr_hit(addr_hit), .irq_edge_high(irq_edge_high));
  ldcb_host_model ldcb_host_model_inst (.clk(clk), .host_io(host_io), .rd_data(rd_data),
    .rd_valid(rd_valid));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] q;
    logic k;
    ldcb_host_model_inst.acc(1'b1, PORT_INDEX, i, q, k);
    ldcb_host_model_inst.acc(1'b1, PORT_DATA, d, q, k);
  endtask

  task automatic rreg(input logic [7:0] i, output logic [7:0] q);
    logic k;
    ldcb_host_model_inst.acc(1'b1, PORT_INDEX, i, q, k);
    ldcb_host_model_inst.acc(1'b0, PORT_DATA, 8'h00, q, k);
    if (k !== 1'b1) begin
      errors++;
      $display("mismatch rd_valid expected 1 seen 0");
      end_sim();
    end
  endtask

  task automatic settle();
    repeat (3) @(negedge clk);
  endtask

  initial begin
    rst = 1'b1;
    cfg_mode = 1'b0;
    ldn = 8'h00;
    pwr_wr = 1'b0;
    pwr_bits = '0;
    host_addr = '0;
    errors = 0;
    checks = 0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    cfg_mode = 1'b1;
    chk("edge_high", 8'h01, {7'h00, irq_edge_high});
    for (int u = 0; u < NUM_UNITS; u++) begin
      ldn = u[7:0];
      for (int k = 0; k < 8; k++) begin
        rreg(ridx[k], v);
        chk("reset", (k == 7 && M_DMA[u]) ? RST_DMA : 8'h00, v);
      end
    end
    $display("test reset done");
    for (int u = 0; u < NUM_UNITS; u++) begin
      ldn = u[7:0];
      for (int k = 0; k < 8; k++) begin
        wreg(ridx[k], 8'hA5 ^ {u[3:0], k[3:0]});
      end
    end
    for (int u = 0; u < NUM_UNITS; u++) begin
      ldn = u[7:0];
      for (int k = 0; k < 8; k++) begin
        rreg(ridx[k], v);
        chk("bank", rft[k][u] ? (8'hA5 ^ {u[3:0], k[3:0]}) & rmsk[k] : 8'h00, v);
      end
    end
    $display("test banks done");
    ldcb_host_model_inst.acc(1'b1, PORT_INDEX, 8'h74, v, ok);
    ldcb_host_model_inst.acc(1'b0, PORT_INDEX, 8'h00, v, ok);
    chk("index", 8'h74, v);
    ldn = 8'h05;
    for (int r = 0; r < 15; r++) begin
      wreg(rsv[r], 8'hFF);
      rreg(rsv[r], v);
      chk("reserved", 8'h00, v);
    end
    $display("test reserved done");
    ldn = 8'h00;
    wreg(8'h70, 8'h03);
    cfg_mode = 1'b0;
    ldcb_host_model_inst.acc(1'b1, PORT_DATA, 8'h09, v, ok);
    ldcb_host_model_inst.acc(1'b0, PORT_DATA, 8'h00, v, ok);
    chk("rd_valid", 8'h00, {7'h00, ok});
    cfg_mode = 1'b1;
    rreg(8'h70, v);
    chk("irq1", 8'h03, v);
    $display("test cfg state done");
    pwr_wr = 1'b1;
    @(negedge clk);
    pwr_wr = 1'b0;
    rreg(8'h30, v);
    chk("act", 8'h00, v);
    chk("on0", 8'h00, {7'h00, unit_on[0]});
    pwr_bits = 10'h010;
    pwr_wr = 1'b1;
    @(negedge clk);
    pwr_wr = 1'b0;
    pwr_bits = '0;
    ldn = 8'h04;
    rreg(8'h30, v);
    chk("act4", 8'h01, v);
    settle();
    chk("on4", 8'h01, {7'h00, unit_on[4]});
    wreg(8'h60, 8'h03);
    wreg(8'h61, 8'hF8);
    host_addr = 12'h3F8;
    settle();
    chk("hit", 8'h01, {7'h00, addr_hit[4]});
    host_addr = 12'h3F0;
    settle();
    chk("miss", 8'h00, {7'h00, addr_hit[4]});
    wreg(8'h60, 8'h00);
    wreg(8'h61, 8'h80);
    host_addr = 12'h080;
    settle();
    chk("window", 8'h00, {7'h00, addr_hit[4]});
    wreg(8'h30, 8'h00);
    settle();
    chk("off4", 8'h00, {7'h00, unit_on[4]});
    ldn = 8'h03;
    wreg(8'h30, 8'h01);
    wreg(8'h60, 8'h01);
    wreg(8'h61, 8'h04);
    chk("cfg3_high", 8'h01, unit_cfg[3].base1[15:8]);
    chk("cfg3_low", 8'h04, unit_cfg[3].base1[7:0]);
    host_addr = 12'h107;
    settle();
    chk("pp_hit", 8'h01, {7'h00, addr_hit[3]});
    host_addr = 12'h103;
    settle();
    chk("pp_miss", 8'h00, {7'h00, addr_hit[3]});
    ldn = 8'h07;
    wreg(8'h30, 8'h01);
    host_addr = 12'h064;
    settle();
    chk("kbd_hit", 8'h01, {7'h00, addr_hit[7]});
    host_addr = 12'h068;
    settle();
    chk("kbd_miss", 8'h00, {7'h00, addr_hit[7]});
    $display("test power and decode done");
    ldn = 8'h0C;
    rreg(8'h60, v);
    chk("no_unit", 8'h00, v);
    ldn = 8'h00;
    rreg(8'h20, v);
    chk("low_index", 8'h00, v);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rreg(8'h74, v);
    chk("dma_rst", RST_DMA, v);
    rreg(8'h70, v);
    chk("irq1_rst", 8'h00, v);
    chk("on7_rst", 8'h00, {7'h00, unit_on[7]});
    $display("test refused and reset done");
    end_sim();
  end
endmodule // testbench
